// >>> hw/bccr_regs.sv
// Capability configuration register slice: clock stop control, link tuning, capability headers
//
// Contract
// - With stop mode 0 the secondary clock is stopped only while the bridge is in D3hot.
// - With stop mode 1 the clock is stopped whenever the bus is idle and nothing is pending.
// - Stop mode bit 15 is writable only when the strap enabled clock power management.
// - Bit 16 resets to 1 and at 1 allows L0s only on receiver electrical idle, else always.
// - Scrambling bits 18:17 reset to 00, L1 timer bits 20:19 reset to 01, bits 31:21 read 0.
// - Bits 7:0 at a8h read the capability identifier 0dh.
// - In legacy mode the pointer at a8h reads f0h.
// - Bits 15:0 at ach read the fixed subsystem vendor identifier.
// - Bits 31:16 at ach read the fixed subsystem identifier.
// - Bits 7:0 at b0h read the express capability identifier 10h.
// - Bits 15:8 at b0h read the next pointer f0h.
// - Bits 19:16 at b0h read version 1 and bits 23:20 read port type 7h.
// - Clock-run enable bit 14 reads 0 without the strap, else is writable and resets to 1.
// - Status bit 13 reads 1 while the secondary clock is stopped, resetting to 0.
module bccr_regs
	import bccr_pkg::*;
#(
	parameter logic [15:0] CARD_VENDOR_ID = 16'h0000,
	parameter logic [15:0] CARD_ID = 16'h0000
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire bccr_bus_req_t bus_req_i,
	output logic [31:0] rdata_o,
	input wire logic [1:0] strap_req_n_i,
	input wire logic d3hot_i,
	input wire logic sec_bus_idle_i,
	input wire logic prim_req_pending_i,
	input wire logic rx_elec_idle_i,
	input wire logic legacy_mode_i,
	input wire logic slot_id_cap_en_i,
	output logic sec_clk_stop_o,
	output logic sec_clkrun_en_o,
	output logic l0s_allow_o,
	output logic [1:0] scramble_ctl_o,
	output logic [1:0] l1_timer_ctl_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	bccr_state_t st_q;
	bccr_state_t st_d;
	logic wr_tuning;
	logic [7:0] subsys_next;
	logic [31:0] tuning_word;
	logic [31:0] subsys_word;
	logic [31:0] card_word;
	logic [31:0] express_word;

	// ----------------------------------------------------------------
	// Read images
	// ----------------------------------------------------------------
	always_comb begin
		if (legacy_mode_i) begin
			subsys_next = NEXT_LEGACY;
		end else if (slot_id_cap_en_i) begin
			subsys_next = NEXT_TO_SLOT_ID;
		end else begin
			subsys_next = NEXT_TO_EXPRESS;
		end
	end

	always_comb begin
		tuning_word = 32'h0000_0000;
		tuning_word[BIT_STOP_STATUS] = st_q.clk_stopped;
		tuning_word[BIT_CLKRUN_EN] = st_q.clkrun_en;
		tuning_word[BIT_STOP_MODE] = st_q.stop_mode;
		tuning_word[BIT_L0S_CTL] = st_q.l0s_ctl;
		tuning_word[SCRAMBLE_LSB +: 2] = st_q.scramble;
		tuning_word[L1_TIMER_LSB +: 2] = st_q.l1_timer;
	end

	assign subsys_word = {16'h0000, subsys_next, SUBSYS_CAP_ID};
	assign card_word = {CARD_ID, CARD_VENDOR_ID};
	assign express_word = {8'h00, EXPRESS_PORT_TYPE, EXPRESS_CAP_VERSION,
		EXPRESS_NEXT, EXPRESS_CAP_ID};

	assign wr_tuning = bus_req_i.wr && (bus_req_i.addr == OFS_LINK_TUNING);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		// Strap is caught on the first clock after reset release
		if (!st_q.strap_done) begin
			st_d.strap_done = 1'b1;
			st_d.cpm_en = (strap_req_n_i == STRAP_CPM_ON);
			st_d.clkrun_en = (strap_req_n_i == STRAP_CPM_ON) ? RST_CLKRUN_EN_CPM : 1'b0;
		end
		// Only the writable fields at the tuning offset take data
		if (wr_tuning) begin
			if (st_q.cpm_en) begin
				st_d.stop_mode = bus_req_i.wdata[BIT_STOP_MODE];
				st_d.clkrun_en = bus_req_i.wdata[BIT_CLKRUN_EN];
			end
			st_d.l0s_ctl = bus_req_i.wdata[BIT_L0S_CTL];
			st_d.scramble = bus_req_i.wdata[SCRAMBLE_LSB +: 2];
			st_d.l1_timer = bus_req_i.wdata[L1_TIMER_LSB +: 2];
		end
		// Clock stop policy follows the mode bit
		if (st_q.stop_mode) begin
			st_d.clk_stopped = sec_bus_idle_i && !prim_req_pending_i;
		end else begin
			st_d.clk_stopped = d3hot_i;
		end
		// Read data stand only in the cycle after the strobe
		st_d.rdata = 32'h0000_0000;
		if (bus_req_i.rd) begin
			unique case (bus_req_i.addr)
				OFS_LINK_TUNING: st_d.rdata = tuning_word;
				OFS_SUBSYS_CAP: st_d.rdata = subsys_word;
				OFS_CARD_ID: st_d.rdata = card_word;
				OFS_EXPRESS_CAP: st_d.rdata = express_word;
				default: st_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			st_q <= ST_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign rdata_o = st_q.rdata;
	assign sec_clk_stop_o = st_q.clk_stopped;
	assign sec_clkrun_en_o = st_q.clkrun_en;
	assign l0s_allow_o = !st_q.l0s_ctl || rx_elec_idle_i;
	assign scramble_ctl_o = st_q.scramble;
	assign l1_timer_ctl_o = st_q.l1_timer;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!nrst_i);

	a_stop_in_d3: assert property (
		(!st_q.stop_mode && d3hot_i) |=> sec_clk_stop_o)
		else $error("clock not stopped in D3hot with mode 0");

	a_run_outside_d3: assert property (
		(!st_q.stop_mode && !d3hot_i) |=> !sec_clk_stop_o)
		else $error("clock stopped outside D3hot with mode 0");

	a_stop_on_idle: assert property (
		(st_q.stop_mode && sec_bus_idle_i && !prim_req_pending_i) |=> sec_clk_stop_o)
		else $error("clock not stopped on idle bus with mode 1");

	a_mode_locked: assert property (
		!st_q.cpm_en |-> !st_q.stop_mode)
		else $error("stop mode set without clock power management");

	a_l0s_gate: assert property (
		(st_q.l0s_ctl && !rx_elec_idle_i) |-> !l0s_allow_o)
		else $error("L0s allowed without receiver idle");

	a_tuning_read: assert property (
		(bus_req_i.rd && bus_req_i.addr == OFS_LINK_TUNING) |=>
		(rdata_o[31:21] == 11'h000 && rdata_o[12:0] == 13'h0000
		&& rdata_o[20:19] == $past(st_q.l1_timer)))
		else $error("tuning read image wrong");

	a_status_read: assert property (
		(bus_req_i.rd && bus_req_i.addr == OFS_LINK_TUNING) |=>
		rdata_o[BIT_STOP_STATUS] == $past(sec_clk_stop_o))
		else $error("stop status bit does not follow clock stop");

	a_subsys_id: assert property (
		(bus_req_i.rd && bus_req_i.addr == OFS_SUBSYS_CAP) |=>
		(rdata_o[7:0] == 8'h0d && rdata_o[31:16] == 16'h0000))
		else $error("subsystem capability identifier wrong");

	a_next_default: assert property (
		(bus_req_i.rd && bus_req_i.addr == OFS_SUBSYS_CAP && !legacy_mode_i
		&& !slot_id_cap_en_i) |=> rdata_o[15:8] == 8'hb0)
		else $error("default next pointer wrong");

	a_next_legacy: assert property (
		(bus_req_i.rd && bus_req_i.addr == OFS_SUBSYS_CAP && legacy_mode_i)
		|=> rdata_o[15:8] == 8'hf0)
		else $error("legacy next pointer wrong");

	a_card_ids: assert property (
		(bus_req_i.rd && bus_req_i.addr == OFS_CARD_ID) |=>
		rdata_o == {CARD_ID, CARD_VENDOR_ID})
		else $error("card identifiers wrong");

	a_express_hdr: assert property (
		(bus_req_i.rd && bus_req_i.addr == OFS_EXPRESS_CAP) |=>
		rdata_o == 32'h0071_f010)
		else $error("express capability header wrong");

	a_clkrun_off: assert property (
		!st_q.cpm_en |-> !sec_clkrun_en_o)
		else $error("clock-run enabled without clock power management");

	a_ro_write: assert property (
		(bus_req_i.wr && bus_req_i.addr != OFS_LINK_TUNING) |=> $stable(st_q.l0s_ctl)
		&& $stable(st_q.scramble) && $stable(st_q.stop_mode))
		else $error("write elsewhere changed tuning state");

	// ----------------------------------------------------------------
	// Clock stop policy and strap capture
	// ----------------------------------------------------------------
	a_run_when_busy: assert property (
		(st_q.stop_mode && !sec_bus_idle_i) |=> !sec_clk_stop_o)
		else $error("clock stopped on busy bus with mode 1");

	a_run_on_pending: assert property (
		(st_q.stop_mode && prim_req_pending_i) |=> !sec_clk_stop_o)
		else $error("clock stopped with primary request pending");

	a_status_reset: assert property (
		$rose(st_q.strap_done) |-> !$past(sec_clk_stop_o))
		else $error("stop status not clear after reset");

	a_strap_taken: assert property (
		$rose(st_q.strap_done) |-> st_q.cpm_en == ($past(strap_req_n_i) == STRAP_CPM_ON))
		else $error("strap not captured after reset release");

	a_strap_held: assert property (
		st_q.strap_done |=> (st_q.strap_done && $stable(st_q.cpm_en)))
		else $error("clock power management changed after capture");

	a_mode_write: assert property (
		(wr_tuning && st_q.cpm_en) |=>
		st_q.stop_mode == $past(bus_req_i.wdata[BIT_STOP_MODE]))
		else $error("stop mode write not taken");

	a_mode_hold: assert property (
		(wr_tuning && !st_q.cpm_en && st_q.strap_done) |=> $stable(st_q.stop_mode))
		else $error("stop mode written without clock power management");

	// ----------------------------------------------------------------
	// Low-power entry and link tuning fields
	// ----------------------------------------------------------------
	a_l0s_free: assert property (
		!st_q.l0s_ctl |-> l0s_allow_o)
		else $error("L0s blocked with control bit 0");

	a_l0s_on_idle: assert property (
		(st_q.l0s_ctl && rx_elec_idle_i) |-> l0s_allow_o)
		else $error("L0s blocked with receiver idle");

	a_l0s_reset: assert property (
		$rose(st_q.strap_done) |-> $past(st_q.l0s_ctl) == RST_L0S_CTL)
		else $error("L0s control not set by reset");

	a_l0s_write: assert property (
		wr_tuning |=> st_q.l0s_ctl == $past(bus_req_i.wdata[BIT_L0S_CTL]))
		else $error("L0s control write not taken");

	a_tuning_reset: assert property (
		$rose(st_q.strap_done) |-> ($past(st_q.scramble) == RST_SCRAMBLE
		&& $past(st_q.l1_timer) == RST_L1_TIMER))
		else $error("tuning fields wrong after reset");

	a_scramble_write: assert property (
		wr_tuning |=> scramble_ctl_o == $past(bus_req_i.wdata[SCRAMBLE_LSB +: 2]))
		else $error("scrambling control write not taken");

	a_timer_write: assert property (
		wr_tuning |=> l1_timer_ctl_o == $past(bus_req_i.wdata[L1_TIMER_LSB +: 2]))
		else $error("L1 timer write not taken");

	a_tuning_fields: assert property (
		(bus_req_i.rd && bus_req_i.addr == OFS_LINK_TUNING) |=>
		(rdata_o[18:17] == $past(st_q.scramble) && rdata_o[16] == $past(st_q.l0s_ctl)))
		else $error("tuning control fields read wrong");

	a_clkrun_default: assert property (
		$rose(st_q.strap_done) |-> sec_clkrun_en_o == st_q.cpm_en)
		else $error("clock-run enable default wrong");

	a_clkrun_write: assert property (
		(wr_tuning && st_q.cpm_en) |=>
		sec_clkrun_en_o == $past(bus_req_i.wdata[BIT_CLKRUN_EN]))
		else $error("clock-run enable write not taken");

	a_clkrun_read: assert property (
		(bus_req_i.rd && bus_req_i.addr == OFS_LINK_TUNING) |=>
		rdata_o[BIT_CLKRUN_EN] == $past(sec_clkrun_en_o))
		else $error("clock-run enable read wrong");

	// ----------------------------------------------------------------
	// Capability images and bus side
	// ----------------------------------------------------------------
	a_next_slot: assert property (
		(bus_req_i.rd && bus_req_i.addr == OFS_SUBSYS_CAP && !legacy_mode_i
		&& slot_id_cap_en_i) |=> rdata_o[15:8] == 8'ha0)
		else $error("slot identification next pointer wrong");

	a_vendor_half: assert property (
		(bus_req_i.rd && bus_req_i.addr == OFS_CARD_ID) |=> rdata_o[15:0] == CARD_VENDOR_ID)
		else $error("card vendor identifier wrong");

	a_card_half: assert property (
		(bus_req_i.rd && bus_req_i.addr == OFS_CARD_ID) |=> rdata_o[31:16] == CARD_ID)
		else $error("card identifier wrong");

	a_express_id: assert property (
		(bus_req_i.rd && bus_req_i.addr == OFS_EXPRESS_CAP) |=> rdata_o[7:0] == 8'h10)
		else $error("express capability identifier wrong");

	a_express_next: assert property (
		(bus_req_i.rd && bus_req_i.addr == OFS_EXPRESS_CAP) |=> rdata_o[15:8] == 8'hf0)
		else $error("express next pointer wrong");

	a_express_type: assert property (
		(bus_req_i.rd && bus_req_i.addr == OFS_EXPRESS_CAP) |=> rdata_o[23:16] == 8'h71)
		else $error("express version or port type wrong");

	a_rdata_idle: assert property (
		!bus_req_i.rd |=> rdata_o == 32'h0000_0000)
		else $error("read data shown without a read");

	a_unmapped_read: assert property (
		(bus_req_i.rd && bus_req_i.addr != OFS_LINK_TUNING && bus_req_i.addr != OFS_SUBSYS_CAP
		&& bus_req_i.addr != OFS_CARD_ID && bus_req_i.addr != OFS_EXPRESS_CAP)
		|=> rdata_o == 32'h0000_0000)
		else $error("unmapped read not zero");

	a_ro_clkrun: assert property (
		(bus_req_i.wr && bus_req_i.addr != OFS_LINK_TUNING && st_q.strap_done) |=>
		($stable(st_q.clkrun_en) && $stable(st_q.l1_timer)))
		else $error("write elsewhere changed clock-run or timer");

	c_mode_write: cover property (wr_tuning && st_q.cpm_en && bus_req_i.wdata[BIT_STOP_MODE]);
	c_idle_stop: cover property (st_q.stop_mode ##1 sec_clk_stop_o);
	c_legacy_read: cover property (bus_req_i.rd && bus_req_i.addr == OFS_SUBSYS_CAP
		&& legacy_mode_i);
	c_slot_read: cover property (bus_req_i.rd && bus_req_i.addr == OFS_SUBSYS_CAP
		&& slot_id_cap_en_i && !legacy_mode_i);
	c_strap_on: cover property ($rose(st_q.strap_done) && st_q.cpm_en);

endmodule

// >>> hw/bccr_pkg.sv
// Package of offsets, field positions, reset values and carriers of the capability register slice
package bccr_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_LINK_TUNING = 8'ha4;
	localparam logic [ADDR_W-1:0] OFS_SUBSYS_CAP = 8'ha8;
	localparam logic [ADDR_W-1:0] OFS_CARD_ID = 8'hac;
	localparam logic [ADDR_W-1:0] OFS_EXPRESS_CAP = 8'hb0;

	// ----------------------------------------------------------------
	// Field positions at the link tuning offset
	// ----------------------------------------------------------------
	localparam int BIT_STOP_STATUS = 13;
	localparam int BIT_CLKRUN_EN = 14;
	localparam int BIT_STOP_MODE = 15;
	localparam int BIT_L0S_CTL = 16;
	localparam int SCRAMBLE_LSB = 17;
	localparam int L1_TIMER_LSB = 19;

	// ----------------------------------------------------------------
	// Reset values and the strap code for clock power management
	// ----------------------------------------------------------------
	localparam logic RST_STOP_MODE = 1'b0;
	localparam logic RST_CLKRUN_EN_CPM = 1'b1;
	localparam logic RST_L0S_CTL = 1'b1;
	localparam logic [1:0] RST_SCRAMBLE = 2'h0;
	localparam logic [1:0] RST_L1_TIMER = 2'h1;
	localparam logic [1:0] STRAP_CPM_ON = 2'h0;

	// ----------------------------------------------------------------
	// Fixed capability values
	// ----------------------------------------------------------------
	localparam logic [7:0] SUBSYS_CAP_ID = 8'h0d;
	localparam logic [7:0] NEXT_TO_EXPRESS = 8'hb0;
	localparam logic [7:0] NEXT_TO_SLOT_ID = 8'ha0;
	localparam logic [7:0] NEXT_LEGACY = 8'hf0;
	localparam logic [7:0] EXPRESS_CAP_ID = 8'h10;
	localparam logic [7:0] EXPRESS_NEXT = 8'hf0;
	localparam logic [3:0] EXPRESS_CAP_VERSION = 4'h1;
	localparam logic [3:0] EXPRESS_PORT_TYPE = 4'h7;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} bccr_bus_req_t;

	typedef struct packed {
		logic strap_done;
		logic cpm_en;
		logic stop_mode;
		logic clkrun_en;
		logic l0s_ctl;
		logic [1:0] scramble;
		logic [1:0] l1_timer;
		logic clk_stopped;
		logic [31:0] rdata;
	} bccr_state_t;

	localparam bccr_state_t ST_RESET = '{
		strap_done: 1'b0,
		cpm_en: 1'b0,
		stop_mode: RST_STOP_MODE,
		clkrun_en: 1'b0,
		l0s_ctl: RST_L0S_CTL,
		scramble: RST_SCRAMBLE,
		l1_timer: RST_L1_TIMER,
		clk_stopped: 1'b0,
		rdata: 32'h0000_0000
	};

endpackage

// >>> dv/bccr_regs_bench.sv
// Self-checking bench for the capability configuration register slice
module bccr_regs_bench import bccr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Signals and design
	// ----------------------------------------------------------------
	localparam logic [15:0] VID = 16'h5a3c; // Arbitrary value
	localparam logic [15:0] CID = 16'hc3a5; // Arbitrary value
	logic clk_sys_i = 1'b0;
	logic nrst_i = 1'b0;
	bccr_bus_req_t req = '0;
	logic [1:0] strap_n = 2'h3;
	logic d3hot = 1'b0, idle = 1'b0, pend = 1'b1, rx_idle = 1'b0, legacy = 1'b0, slot_en = 1'b0;
	logic [31:0] rdata_o;
	logic stop_o, clkrun_o, l0s_o;
	logic [1:0] scr_o, l1_o;
	int err_total = 0;
	int total_checks = 0;

	always #5 clk_sys_i = ~clk_sys_i;

	bccr_regs #(.CARD_VENDOR_ID(VID), .CARD_ID(CID)) dut (
		.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .bus_req_i(req), .rdata_o(rdata_o),
		.strap_req_n_i(strap_n), .d3hot_i(d3hot), .sec_bus_idle_i(idle),
		.prim_req_pending_i(pend), .rx_elec_idle_i(rx_idle), .legacy_mode_i(legacy),
		.slot_id_cap_en_i(slot_en), .sec_clk_stop_o(stop_o), .sec_clkrun_en_o(clkrun_o),
		.l0s_allow_o(l0s_o), .scramble_ctl_o(scr_o), .l1_timer_ctl_o(l1_o)
	);

	// ----------------------------------------------------------------
	// Bus, pin, reset and compare tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys_i);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk_sys_i);
		req.rd <= 1'b0;
		#1 chk($sformatf("read %h", a), exp, rdata_o);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk_sys_i);
		req.wr <= 1'b0;
	endtask

	task automatic pins(input logic d3, input logic idl, input logic pnd);
		@(posedge clk_sys_i);
		d3hot <= d3;
		idle <= idl;
		pend <= pnd;
		@(posedge clk_sys_i);
		#1;
	endtask

	task automatic do_reset(input logic [1:0] s);
		@(posedge clk_sys_i);
		nrst_i <= 1'b0;
		strap_n <= s;
		repeat (5) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_consts();
		rd(8'hb0, 32'h0071_f010);
		@(posedge clk_sys_i);
		#1 chk("rdata after read", 32'h0, rdata_o);
		rd(8'hac, {CID, VID});
		rd(8'ha8, 32'h0000_b00d);
		@(posedge clk_sys_i);
		slot_en <= 1'b1;
		rd(8'ha8, 32'h0000_a00d);
		@(posedge clk_sys_i);
		legacy <= 1'b1;
		rd(8'ha8, 32'h0000_f00d);
		@(posedge clk_sys_i);
		legacy <= 1'b0;
		slot_en <= 1'b0;
		wr(8'ha8, 32'hffff_ffff);
		wr(8'hac, 32'hffff_ffff);
		wr(8'hb0, 32'hffff_ffff);
		rd(8'ha8, 32'h0000_b00d);
		rd(8'hac, {CID, VID});
		rd(8'hb0, 32'h0071_f010);
		rd(8'h40, 32'h0);
	endtask

	task automatic t_cpm_off();
		do_reset(2'h1);
		rd(8'ha4, 32'h0009_0000);
		wr(8'ha4, 32'hffff_ffff);
		rd(8'ha4, 32'h001f_0000);
		chk("clkrun enable", 32'h0, {31'h0, clkrun_o});
		chk("scramble", 32'h3, {30'h0, scr_o});
		chk("l1 timer", 32'h3, {30'h0, l1_o});
		chk("l0s busy rx", 32'h0, {31'h0, l0s_o});
		@(posedge clk_sys_i);
		rx_idle <= 1'b1;
		@(posedge clk_sys_i);
		#1 chk("l0s idle rx", 32'h1, {31'h0, l0s_o});
		wr(8'ha4, 32'h0);
		rx_idle <= 1'b0;
		@(posedge clk_sys_i);
		#1 chk("l0s free", 32'h1, {31'h0, l0s_o});
	endtask

	task automatic t_d3();
		pins(1'b0, 1'b1, 1'b0);
		chk("stop idle mode0", 32'h0, {31'h0, stop_o});
		pins(1'b1, 1'b1, 1'b0);
		chk("stop d3hot", 32'h1, {31'h0, stop_o});
		rd(8'ha4, 32'h0000_2000);
		pins(1'b0, 1'b0, 1'b1);
		chk("stop leaves d3hot", 32'h0, {31'h0, stop_o});
	endtask

	task automatic t_cpm_on();
		do_reset(2'h0);
		rd(8'ha4, 32'h0009_4000);
		chk("clkrun enable", 32'h1, {31'h0, clkrun_o});
		wr(8'ha4, 32'h0000_8000);
		rd(8'ha4, 32'h0000_8000);
		chk("clkrun cleared", 32'h0, {31'h0, clkrun_o});
		pins(1'b0, 1'b1, 1'b0);
		chk("stop idle mode1", 32'h1, {31'h0, stop_o});
		rd(8'ha4, 32'h0000_a000);
		pins(1'b0, 1'b1, 1'b1);
		chk("stop pending", 32'h0, {31'h0, stop_o});
		pins(1'b0, 1'b0, 1'b0);
		chk("stop busy", 32'h0, {31'h0, stop_o});
	endtask

	// ----------------------------------------------------------------
	// Sequence, watchdog and verdict
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		do_reset(2'h3);
		t_consts();
		t_cpm_off();
		t_d3();
		t_cpm_on();
		report_and_stop();
	end

	initial begin
		#20000;
		err_total++;
		report_and_stop();
	end
endmodule
